// File: dds_clock_power_config.sv
// Purpose: Configuration and control of a DDS: clock multiplier, power-down, bypass, port mode
// Assumes: Host port already decoded to byte accesses; ref clock slower than half of mclk
// Notes:   Host writes go to a buffer and reach the active bank only on an update
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg_consts.svh"

// Functional notes
// RL1 - Inverse sinc on after reset; bypass bit in path register turns it off.
// RL2 - Q path skips inverse sinc when Q converter takes external data.
// RL3 - Five-bit clock register field holds multiplier factor 4 to 20 in binary.
// RL4 - System clock from multiplier when engaged, else straight from reference.
// RL5 - Multiplier bypass bit in clock register disables multiplication.
// RL6 - Host sets PLL range bit for 200-300 MHz system clock, clears it below.
// RL7 - Each power register bit high switches its stage off, low keeps it on.
// RL8 - Full power-down only when all four power-down bits are high.
// RL9 - Path register bypass bits remove inverse sinc and multiplier stages; the code bypasses the multiplier when enable bit 5 is low instead.
// RL10 - Host port parallel when mode pin high, serial when low.
// RL11 - Every register writable and readable in either port mode.
// RL12 - Writes act only after buffer copied to active bank by timer or pin.
// RL13 - Buffer writes need no reference clock; bank copy needs it running.
// RL14 - Controller holds master reset high at least 10 system clocks; the bench holds its first reset for 8.
// RL15 - Master reset restarts port logic and loads every register default.
// RL16 - Timer counts 32-bit value down at half rate, updates at zero.
// RL17 - Bank copy updates every buffered register together on one edge.
module dds_clock_power_config #(
   parameter int REF_LOSS = 64
) (
   input  wire logic               mclk,
   input  wire logic               srst,
   input  wire logic [5:0]         addr,
   input  wire logic [7:0]         wdata,
   input  wire logic               wr_stb,
   input  wire logic               rd_stb,
   output logic [7:0]              rdata,
   input  wire logic               ref_clock_in,
   input  wire logic               port_mode_pin,
   output logic                    host_parallel,
   input  wire logic               bank_update_strobe_in,
   output logic                    bank_update_strobe_out,
   output logic                    bank_update_strobe_oe,
   output logic                    ref_running,
   output dds_cfg_pkg::cfg_t       cfg
);
   import dds_cfg_pkg::*;

   if (REF_LOSS < 4 || REF_LOSS > 65535) begin : g_bad_ref_loss
      $error("dds_clock_power_config: REF_LOSS out of range");
   end

   localparam logic [15:0] REF_LOSS_CNT = 16'(REF_LOSS);

   // ************************************************************
   // Host access decode
   // ************************************************************
   buf_req_t   req;
   logic [2:0] idx;
   logic       hit;

   // Both port modes reach the same buffer through this decode
   always_comb begin
      idx = 3'h0;
      hit = 1'b1;
      if (addr == `OFS_UPD_CNT3) begin
         idx = `IDX_UPD_CNT3;
      end else if (addr == `OFS_UPD_CNT2) begin
         idx = `IDX_UPD_CNT2;
      end else if (addr == `OFS_UPD_CNT1) begin
         idx = `IDX_UPD_CNT1;
      end else if (addr == `OFS_UPD_CNT0) begin
         idx = `IDX_UPD_CNT0;
      end else if (addr == `OFS_POWER) begin
         idx = `IDX_POWER;
      end else if (addr == `OFS_CLOCK) begin
         idx = `IDX_CLOCK;
      end else if (addr == `OFS_MODE) begin
         idx = `IDX_MODE;
      end else if (addr == `OFS_PATH) begin
         idx = `IDX_PATH;
      end else begin
         hit = 1'b0;
      end
      req.wr   = wr_stb; // RL11
      req.rd   = rd_stb; // RL11
      req.hit  = hit;
      req.idx  = idx;
      req.data = wdata;
   end

   // ************************************************************
   // Write buffer
   // ************************************************************
   logic [63:0] buf_bytes;

   // Buffer runs on mclk alone, so writes land with no reference clock
   cfg_byte_buffer #(
      .SLOTS    (8)
   ) u_buffer (
      .mclk     (mclk),
      .srst     (srst),
      .req      (req),
      .rdata    (rdata),
      .contents (buf_bytes)
   ); // RL12 RL13

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] mode_sync_q;
   logic [1:0] mode_sync_d;
   logic [2:0] ref_sync_q;
   logic [2:0] ref_sync_d;
   logic [2:0] upd_sync_q;
   logic [2:0] upd_sync_d;

   always_comb begin
      mode_sync_d = {mode_sync_q[0], port_mode_pin};
      ref_sync_d  = {ref_sync_q[1:0], ref_clock_in};
      upd_sync_d  = {upd_sync_q[1:0], bank_update_strobe_in};
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mode_sync_q <= 2'b00;
         ref_sync_q  <= 3'b000;
         upd_sync_q  <= 3'b000;
      end else begin
         mode_sync_q <= mode_sync_d;
         ref_sync_q  <= ref_sync_d;
         upd_sync_q  <= upd_sync_d;
      end
   end

   logic host_parallel_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         host_parallel_q <= 1'b0;
      end else begin
         host_parallel_q <= mode_sync_q[1]; // RL10
      end
   end

   assign host_parallel = host_parallel_q;

   // ************************************************************
   // Reference clock activity
   // ************************************************************
   logic [15:0] ref_idle_q;
   logic [15:0] ref_idle_d;
   logic        ref_run_q;
   logic        ref_run_d;

   // Limitation: a reference faster than mclk/2 aliases and may look stopped
   always_comb begin
      ref_idle_d = ref_idle_q;
      ref_run_d  = ref_run_q;
      if (ref_sync_q[2] != ref_sync_q[1]) begin
         ref_idle_d = 16'h0000;
         ref_run_d  = 1'b1;
      end else if (ref_idle_q >= REF_LOSS_CNT) begin
         ref_run_d  = 1'b0;
      end else begin
         ref_idle_d = ref_idle_q + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_idle_q <= 16'h0000;
         ref_run_q  <= 1'b0;
      end else begin
         ref_idle_q <= ref_idle_d;
         ref_run_q  <= ref_run_d;
      end
   end

   assign ref_running = ref_run_q;

   // ************************************************************
   // Active bank
   // ************************************************************
   logic [63:0] bank_q;
   logic [63:0] bank_d;
   cfg_t        cfg_q;
   cfg_t        cfg_d;
   logic        timer_tick;
   logic        ext_rise;
   logic        upd_req;

   // Decode of the buffer as it would look once copied
   function automatic cfg_t decode(input logic [63:0] b);
      logic [7:0] pwr;
      logic [7:0] clk;
      logic [7:0] mode;
      logic [7:0] path;
      cfg_t       c;
      pwr  = b[`IDX_POWER*8 +: 8];
      clk  = b[`IDX_CLOCK*8 +: 8];
      mode = b[`IDX_MODE*8 +: 8];
      path = b[`IDX_PATH*8 +: 8];
      c.inv_sinc_i_on   = ~path[`POS_SINC_BYPASS]; // RL1 RL9
      c.q_src_ext       = mode[`POS_Q_SRC_EXT];
      c.inv_sinc_q_on   = ~path[`POS_SINC_BYPASS] & ~mode[`POS_Q_SRC_EXT]; // RL2
      c.dig_mult_bypass = ~path[`POS_DMULT_EN]; // RL9
      c.osk_internal    = path[`POS_OSK_INT];
      c.pll_bypass      = clk[`POS_PLL_BYPASS]; // RL5
      c.sysclk_from_ref = clk[`POS_PLL_BYPASS]; // RL4
      c.pll_range       = clk[`POS_PLL_RANGE];
      c.mult_factor     = clk[`POS_MULT_LO +: 5]; // RL3
      c.mult_factor_ok  = (clk[`POS_MULT_LO +: 5] >= `MULT_MIN) &&
                          (clk[`POS_MULT_LO +: 5] <= `MULT_MAX); // RL3
      c.stage_off_bit   = {pwr[`POS_OFF_COMP], pwr[`POS_OFF_QDAC],
                           pwr[`POS_OFF_DAC], pwr[`POS_OFF_DIGITAL]}; // RL7
      c.full_power_down = pwr[`POS_OFF_COMP] & pwr[`POS_OFF_QDAC] &
                          pwr[`POS_OFF_DAC] & pwr[`POS_OFF_DIGITAL]; // RL8
      c.internal_update = mode[`POS_INT_UPDATE];
      return c;
   endfunction

   // External strobe only counts while the pin is an input
   assign ext_rise = upd_sync_q[1] & ~upd_sync_q[2] & ~cfg_q.internal_update;
   assign upd_req  = (timer_tick | ext_rise) & ref_run_q; // RL12 RL13

   always_comb begin
      bank_d = bank_q;
      cfg_d  = cfg_q;
      if (upd_req) begin
         bank_d = buf_bytes; // RL17
         cfg_d  = decode(buf_bytes); // RL17
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bank_q <= {`RST_PATH, `RST_MODE, `RST_CLOCK, `RST_POWER,
                    `RST_UPD_CNT0, `RST_UPD_CNT1, `RST_UPD_CNT2, `RST_UPD_CNT3}; // RL15
         cfg_q  <= decode({`RST_PATH, `RST_MODE, `RST_CLOCK, `RST_POWER,
                           `RST_UPD_CNT0, `RST_UPD_CNT1, `RST_UPD_CNT2, `RST_UPD_CNT3}); // RL15
      end else begin
         bank_q <= bank_d;
         cfg_q  <= cfg_d;
      end
   end

   assign cfg = cfg_q;

   // ************************************************************
   // Internal update timer
   // ************************************************************
   logic [31:0] upd_count;

   assign upd_count = {bank_q[`IDX_UPD_CNT3*8 +: 8], bank_q[`IDX_UPD_CNT2*8 +: 8],
                       bank_q[`IDX_UPD_CNT1*8 +: 8], bank_q[`IDX_UPD_CNT0*8 +: 8]};

   update_timer #(
      .WIDTH      (32)
   ) u_timer (
      .mclk       (mclk),
      .srst       (srst),
      .run        (cfg_q.internal_update),
      .load_value (upd_count),
      .tick       (timer_tick)
   ); // RL16

   // ************************************************************
   // Update pin driver
   // ************************************************************
   logic [3:0] pin_hi_q;
   logic [3:0] pin_hi_d;

   // Short periods keep the pin high: the pulse outlasts the period
   always_comb begin
      pin_hi_d = pin_hi_q;
      if (timer_tick) begin
         pin_hi_d = `UPD_PIN_HIGH;
      end else if (pin_hi_q != 4'h0) begin
         pin_hi_d = pin_hi_q - 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_hi_q <= 4'h0;
      end else begin
         pin_hi_q <= pin_hi_d;
      end
   end

   assign bank_update_strobe_out = pin_hi_q != 4'h0;
   assign bank_update_strobe_oe  = cfg_q.internal_update;

endmodule
`default_nettype wire

// File: dds_cfg_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the DDS clock/power configuration block
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses of the 6-bit host port
`ifndef DDS_CFG_CONSTS_SVH
`define DDS_CFG_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_UPD_CNT3      6'h16
`define OFS_UPD_CNT2      6'h17
`define OFS_UPD_CNT1      6'h18
`define OFS_UPD_CNT0      6'h19
`define OFS_POWER         6'h1D
`define OFS_CLOCK         6'h1E
`define OFS_MODE          6'h1F
`define OFS_PATH          6'h20

// ************************************************************
// Buffer slot of each register
// ************************************************************
`define IDX_UPD_CNT3      3'h0
`define IDX_UPD_CNT2      3'h1
`define IDX_UPD_CNT1      3'h2
`define IDX_UPD_CNT0      3'h3
`define IDX_POWER         3'h4
`define IDX_CLOCK         3'h5
`define IDX_MODE          3'h6
`define IDX_PATH          3'h7

// ************************************************************
// Field positions
// ************************************************************
`define POS_OFF_DIGITAL   0
`define POS_OFF_DAC       1
`define POS_OFF_QDAC      2
`define POS_OFF_COMP      4
`define POS_MULT_LO       0
`define POS_PLL_BYPASS    5
`define POS_PLL_RANGE     6
`define POS_INT_UPDATE    0
`define POS_Q_SRC_EXT     4
`define POS_OSK_INT       4
`define POS_DMULT_EN      5
`define POS_SINC_BYPASS   6

// ************************************************************
// Reset values
// ************************************************************
`define RST_UPD_CNT3      8'h00
`define RST_UPD_CNT2      8'h00
`define RST_UPD_CNT1      8'h00
`define RST_UPD_CNT0      8'h40
`define RST_POWER         8'h00
`define RST_CLOCK         8'h04
`define RST_MODE          8'h01
`define RST_PATH          8'h00

// ************************************************************
// Limits and counts
// ************************************************************
`define MULT_MIN          5'h04
`define MULT_MAX          5'h14
`define UPD_PIN_HIGH      4'h8
`define REF_LOSS_CYCLES   16'h0040

`endif

// File: dds_cfg_pkg.sv
// Purpose: Types shared by the DDS clock/power configuration block
// Assumes: None
// Notes:   Constants live in dds_cfg_consts.svh
package dds_cfg_pkg;

   // Active configuration as seen by the datapath and analog stages
   typedef struct packed {
      logic       inv_sinc_i_on;
      logic       inv_sinc_q_on;
      logic       dig_mult_bypass;
      logic       osk_internal;
      logic       q_src_ext;
      logic       pll_bypass;
      logic       sysclk_from_ref;
      logic       pll_range;
      logic [4:0] mult_factor;
      logic       mult_factor_ok;
      logic [3:0] stage_off_bit;
      logic       full_power_down;
      logic       internal_update;
   } cfg_t;

   // Host access towards the write buffer
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       hit;
      logic [2:0] idx;
      logic [7:0] data;
   } buf_req_t;

endpackage

// File: cfg_byte_buffer.sv
// Purpose: Host write buffer of the configuration bytes
// Assumes: One access per cycle from the host decoder
// Notes:   Read data registered; whole contents visible for the bank copy
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg_consts.svh"

module cfg_byte_buffer #(
   parameter int SLOTS = 8
) (
   input  wire logic                    mclk,
   input  wire logic                    srst,
   input  wire dds_cfg_pkg::buf_req_t   req,
   output logic [7:0]                   rdata,
   output logic [SLOTS*8-1:0]           contents
);
   import dds_cfg_pkg::*;

   if (SLOTS != 8) begin : g_bad_slots
      $error("cfg_byte_buffer: SLOTS must be 8");
   end

   logic [SLOTS*8-1:0] mem_q;
   logic [SLOTS*8-1:0] mem_d;
   logic [7:0]         rdata_q;
   logic [7:0]         rdata_d;

   always_comb begin
      mem_d   = mem_q;
      rdata_d = rdata_q;
      if (req.wr && req.hit) begin
         mem_d[req.idx*8 +: 8] = req.data;
      end
      if (req.rd) begin
         rdata_d = req.hit ? mem_q[req.idx*8 +: 8] : 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mem_q   <= {`RST_PATH, `RST_MODE, `RST_CLOCK, `RST_POWER,
                     `RST_UPD_CNT0, `RST_UPD_CNT1, `RST_UPD_CNT2, `RST_UPD_CNT3};
         rdata_q <= 8'h00;
      end else begin
         mem_q   <= mem_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata    = rdata_q;
   assign contents = mem_q;

endmodule
`default_nettype wire

// File: update_timer.sv
// Purpose: Internal bank-update timer
// Assumes: load_value stable while running, changes only at a bank update
// Notes:   Counts at half the system clock; pulse period is 2*(N+1) cycles
`timescale 1ns/1ps
`default_nettype none

module update_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] load_value,
   output logic                  tick
);
   if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
      $error("update_timer: WIDTH out of range");
   end

   logic             half_q;
   logic             half_d;
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic             tick_q;
   logic             tick_d;

   always_comb begin
      half_d = 1'b0;
      cnt_d  = load_value;
      tick_d = 1'b0;
      if (run) begin
         half_d = ~half_q;
         cnt_d  = cnt_q;
         if (half_q) begin
            if (cnt_q == '0) begin
               cnt_d  = load_value;
               tick_d = 1'b1;
            end else begin
               cnt_d  = cnt_q - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         half_q <= 1'b0;
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         half_q <= half_d;
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule
`default_nettype wire

// File: dds_cfg_chk.sv
// Purpose: Port assertions for the DDS clock/power configuration block
// Assumes: One clock, mclk; synchronous active-high srst
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg_consts.svh"

module dds_cfg_chk #(
   parameter int REF_LOSS = 64
) (
   input  wire logic              mclk,
   input  wire logic              srst,
   input  wire logic [5:0]        addr,
   input  wire logic              rd_stb,
   input  wire logic [7:0]        rdata,
   input  wire logic              port_mode_pin,
   input  wire logic              host_parallel,
   input  wire logic              bank_update_strobe_out,
   input  wire logic              bank_update_strobe_oe,
   input  wire logic              ref_running,
   input  wire dds_cfg_pkg::cfg_t cfg
);
   import dds_cfg_pkg::*;

   logic [2:0] age_q;
   logic [2:0] age_d;

   // Mode pin synchroniser needs a few cycles after reset
   always_comb begin
      age_d = srst ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
   end

   always_ff @(posedge mclk) begin
      age_q <= age_d;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   // ************************************************************
   // Assertions
   // ************************************************************
   a_oe_follows_mode: assert property (bank_update_strobe_oe == cfg.internal_update)
      else $error("update pin drive does not follow update mode");
   a_full_off_all: assert property (cfg.full_power_down == (&cfg.stage_off_bit))
      else $error("full power-down not the and of the stage bits");
   a_q_skips_sinc: assert property (cfg.inv_sinc_q_on == (cfg.inv_sinc_i_on && !cfg.q_src_ext))
      else $error("Q inverse sinc state wrong");
   a_clk_from_ref: assert property (cfg.sysclk_from_ref == cfg.pll_bypass)
      else $error("system clock source disagrees with bypass");
   a_mult_valid: assert property (cfg.mult_factor_ok == (cfg.mult_factor >= `MULT_MIN && cfg.mult_factor <= `MULT_MAX))
      else $error("multiplier valid flag wrong");
   a_pulse_eight: assert property ($rose(bank_update_strobe_out) |-> bank_update_strobe_out [*8] ##1 !bank_update_strobe_out)
      else $error("update pulse not eight cycles high");
   a_cfg_needs_ref: assert property ($changed(cfg) |-> $past(ref_running) || $past(ref_running, 2))
      else $error("bank changed without reference clock");
   a_rdata_on_read: assert property ($changed(rdata) |-> $past(rd_stb))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd_stb && !(addr inside {[6'h16:6'h19], [6'h1D:6'h20]}) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_mode_pin: assert property ((age_q == 3'h7 && $stable(port_mode_pin)) [*4] |-> host_parallel == port_mode_pin)
      else $error("port mode does not follow pin");

   c_full_off: cover property (cfg.full_power_down);
   c_external: cover property (!bank_update_strobe_oe);
   c_timer_pulse: cover property ($rose(bank_update_strobe_out));
endmodule

bind dds_clock_power_config dds_cfg_chk #(.REF_LOSS(REF_LOSS)) u_chk (
   .mclk(mclk), .srst(srst), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
   .port_mode_pin(port_mode_pin), .host_parallel(host_parallel),
   .bank_update_strobe_out(bank_update_strobe_out), .bank_update_strobe_oe(bank_update_strobe_oe),
   .ref_running(ref_running), .cfg(cfg));
`default_nettype wire

// File: ref_update_source.sv
// Purpose: Far-side model: reference clock source and external update driver
// Assumes: Update pin has a pull-down when nobody drives it
// Notes:   Reference stands still while ref_on is low
`timescale 1ns/1ps
`default_nettype none

module ref_update_source (
   input  wire logic ref_on,
   input  wire logic upd_oe,
   output logic      ref_clock_in,
   output logic      upd_en,
   output logic      upd_drv
);
   initial begin
      ref_clock_in = 1'b0;
      upd_en = 1'b0;
      upd_drv = 1'b0;
   end

   // Odd half period keeps the reference unrelated to mclk
   always #6.3 if (ref_on) ref_clock_in = !ref_clock_in;

   // Drives the pin only while the device has let go of it
   task automatic pulse();
      if (!upd_oe) begin
         upd_en = 1'b1;
         upd_drv = 1'b1;
         #40;
         upd_drv = 1'b0;
         #40;
         upd_en = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench of the DDS clock/power configuration block
// Assumes: Reads return the buffer, bank follows on updates
// Notes:   REF_LOSS shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import dds_cfg_pkg::*;
   logic       mclk, srst, wr_stb, rd_stb, port_mode_pin, ref_on, rd_q;
   logic       host_parallel, upd_out, upd_oe, ref_running, ref_clk, upd_en, upd_drv;
   logic [5:0] addr;
   logic [7:0] wdata, rdata;
   wire logic  upd_wire;
   cfg_t       cfg, old;
   int         mismatches, samples_checked, seed, n;
   logic [7:0] exp_q [$];
   logic [7:0] sh [6'h16:6'h20];
   logic [7:0] ctab [6] = '{8'h03, 8'h04, 8'h14, 8'h15, 8'h25, 8'h45};
   logic [7:0] ptab [6] = '{8'h17, 8'h07, 8'h10, 8'h00, 8'h0F, 8'h17};

   always #2 mclk = ~mclk;

   dds_clock_power_config #(.REF_LOSS(16)) u_dut (
      .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .ref_clock_in(ref_clk), .port_mode_pin(port_mode_pin), .host_parallel(host_parallel),
      .bank_update_strobe_in(upd_wire), .bank_update_strobe_out(upd_out), .bank_update_strobe_oe(upd_oe),
      .ref_running(ref_running), .cfg(cfg));

   ref_update_source u_far (.ref_on(ref_on), .upd_oe(upd_oe), .ref_clock_in(ref_clk),
      .upd_en(upd_en), .upd_drv(upd_drv));

   assign upd_wire = upd_oe ? upd_out : (upd_en ? upd_drv : 1'b0);

   // ************************************************************
   // Expectations and bus tasks
   // ************************************************************
   function automatic cfg_t ecfg(logic [7:0] p, c, m, a);
      cfg_t e;
      e.inv_sinc_i_on   = !a[6];
      e.inv_sinc_q_on   = !a[6] && !m[4];
      e.dig_mult_bypass = !a[5];
      e.osk_internal    = a[4];
      e.q_src_ext       = m[4];
      e.pll_bypass      = c[5];
      e.sysclk_from_ref = c[5];
      e.pll_range       = c[6];
      e.mult_factor     = c[4:0];
      e.mult_factor_ok  = c[4:0] >= 5'h04 && c[4:0] <= 5'h14;
      e.stage_off_bit   = {p[4], p[2], p[1], p[0]};
      e.full_power_down = &e.stage_off_bit;
      e.internal_update = m[0];
      return e;
   endfunction

   function automatic cfg_t exp_cfg();
      return ecfg(sh[6'h1D], sh[6'h1E], sh[6'h1F], sh[6'h20]);
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      if (a inside {[6'h16:6'h19], [6'h1D:6'h20]}) sh[a] = d;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      rd_stb <= 1'b0;
   endtask

   task automatic rd_all();
      for (int a = 6'h16; a <= 6'h20; a++)
         rd(6'(a), sh[a]);
      rd(6'h3A, 8'h00);
   endtask

   task automatic do_reset(input int cyc);
      srst <= 1'b1;
      repeat (cyc) @(posedge mclk);
      srst <= 1'b0;
      foreach (sh[i]) sh[i] = 8'h00;
      sh[6'h19] = 8'h40;
      sh[6'h1E] = 8'h04;
      sh[6'h1F] = 8'h01;
   endtask

   task automatic wait_cfg(input cfg_t e, input int lim);
      int k;
      k = 0;
      while (cfg !== e && k < lim) begin
         @(posedge mclk);
         k++;
      end
      check(cfg, e);
      if (cfg !== e) summarize();
   endtask

   task automatic till(input logic v, inout int k);
      while (upd_out !== v && k < 400) begin
         @(posedge mclk);
         k++;
      end
   endtask

   // Read data checked one cycle after each read strobe
   always @(posedge mclk) begin
      if (rd_q && exp_q.size() > 0) check(rdata, exp_q.pop_front());
      rd_q <= rd_stb;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      mclk = 1'b0; srst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; rd_q = 1'b0;
      addr = 6'h00; wdata = 8'h00; port_mode_pin = 1'b0; ref_on = 1'b0;
      seed = 32'hf10b; mismatches = 0; samples_checked = 0;
      do_reset(8);
      check(cfg, exp_cfg());
      check(upd_oe, 1'b1);
      rd_all();
      for (int i = 0; i < 2; i++) begin
         port_mode_pin <= (i == 0);
         repeat (6) @(posedge mclk);
         check(host_parallel, (i == 0));
      end
      // No reference: buffer takes writes, bank holds
      old = exp_cfg();
      wr(6'h18, 8'h00);
      wr(6'h19, 8'h05);
      wr(6'h1D, 8'($random(seed)));
      wr(6'h1E, 8'h45);
      wr(6'h20, 8'($random(seed)));
      wr(6'h3A, 8'h5A);
      rd_all();
      repeat (300) @(posedge mclk);
      check(cfg, old);
      ref_on = 1'b1;
      wait_cfg(exp_cfg(), 400);
      repeat (30) @(posedge mclk);
      n = 0;
      till(1'b0, n);
      till(1'b1, n);
      n = 0;
      till(1'b0, n);
      till(1'b1, n);
      check(n, 12);
      if (n >= 400) summarize();
      wr(6'h1F, 8'h00);
      wait_cfg(exp_cfg(), 400);
      check(upd_oe, 1'b0);
      // External update only from here on
      for (int i = 0; i < 6; i++) begin
         old = exp_cfg();
         wr(6'h1E, ctab[i]);
         wr(6'h1D, ptab[i]);
         wr(6'h20, 8'($random(seed)));
         wr(6'h1F, {3'h0, i[0], 4'h0});
         repeat (20) @(posedge mclk);
         check(cfg, old);
         u_far.pulse();
         wait_cfg(exp_cfg(), 40);
      end
      ref_on = 1'b0;
      repeat (40) @(posedge mclk);
      check(ref_running, 1'b0);
      old = exp_cfg();
      wr(6'h1E, 8'h08);
      u_far.pulse();
      repeat (20) @(posedge mclk);
      check(cfg, old);
      ref_on = 1'b1;
      repeat (20) @(posedge mclk);
      check(ref_running, 1'b1);
      u_far.pulse();
      wait_cfg(exp_cfg(), 40);
      do_reset(10);
      check(cfg, exp_cfg());
      rd_all();
      repeat (4) @(posedge mclk);
      summarize();
   end
endmodule
`default_nettype wire
